// [rtl/pcm_pkg.sv]
// constants, types and reset image for the per-port phy configuration map
// assumes a single clock domain and 32-bit axi4-lite register access
package pcm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int NPORT   = 4;
  localparam int NREG    = 8;
  localparam int AXI_AW  = 12;

  ////////////////////////////////////////////////////////////////////////////
  // register slots inside one port bank
  localparam logic [2:0] IDX_LINK   = 3'h0;
  localparam logic [2:0] IDX_PHYP2  = 3'h1;
  localparam logic [2:0] IDX_PHYCTL = 3'h2;
  localparam logic [2:0] IDX_DCNT   = 3'h3;
  localparam logic [2:0] IDX_PHYP3  = 3'h4;
  localparam logic [2:0] IDX_PML1   = 3'h5;
  localparam logic [2:0] IDX_DEEMPH = 3'h6;
  localparam logic [2:0] IDX_LTSSM  = 3'h7;

  // byte offsets inside a port window; port number sits in address [11:10]
  localparam logic [9:0] OFS_LINK   = 10'h078;
  localparam logic [9:0] OFS_PHYP2  = 10'h07c;
  localparam logic [9:0] OFS_PHYCTL = 10'h080;
  localparam logic [9:0] OFS_DCNT   = 10'h08c;
  localparam logic [9:0] OFS_PHYP3  = 10'h090;
  localparam logic [9:0] OFS_PML1   = 10'h098;
  localparam logic [9:0] OFS_DEEMPH = 10'h0f0;
  localparam logic [9:0] OFS_LTSSM  = 10'h33c;
  localparam logic [9:0] OFS_STATUS = 10'h3fc;

  ////////////////////////////////////////////////////////////////////////////
  // memory word addresses (first port of each group)
  localparam logic [7:0] WADR_LINK0   = 8'h20;
  localparam logic [7:0] WADR_LTSSM0  = 8'h28;
  localparam logic [7:0] WADR_PHYP2_0 = 8'h30;
  localparam logic [7:0] WADR_PHYCTL0 = 8'h38;
  localparam logic [7:0] WADR_MIXED0  = 8'h40;

  ////////////////////////////////////////////////////////////////////////////
  // field positions in the target registers
  localparam int POS_LTSSM    = 0;
  localparam int POS_L1_ALL   = 24;
  localparam int POS_L1_OFF   = 25;
  localparam int POS_CLKREQ   = 26;
  localparam int POS_P2HI     = 16;
  localparam int POS_P2LO     = 8;
  localparam int POS_PHYCTL   = 0;
  localparam int POS_P3       = 0;
  localparam int POS_DEEMPH   = 6;
  localparam int POS_CMPL_DET = 11;
  localparam int POS_DCNT     = 8;
  localparam int POS_SPEED_EN = 14;

  localparam logic [31:0] MSK_LTSSM    = 32'h0000_00ff;
  localparam logic [31:0] MSK_PML1     = 32'h0f00_0000;
  localparam logic [31:0] MSK_P2HI     = 32'h7fff_0000;
  localparam logic [31:0] MSK_PHYCTL   = 32'h0000_ffff;
  localparam logic [31:0] MSK_P2LO     = 32'h0000_1f00;
  localparam logic [31:0] MSK_P3       = 32'h0000_007f;
  localparam logic [31:0] MSK_DEEMPH   = 32'h0000_0040;
  localparam logic [31:0] MSK_CMPL_DET = 32'h0000_0800;
  localparam logic [31:0] MSK_DCNT     = 32'h0000_0300;
  localparam logic [31:0] MSK_SPEED_EN = 32'h0000_4000;

  ////////////////////////////////////////////////////////////////////////////
  // reset values: registers start as if the default words were loaded
  localparam logic [31:0] RST_LTSSM    = 32'h0000_0004;
  localparam logic [31:0] RST_PHYP2_01 = 32'h0010_1d00;
  localparam logic [31:0] RST_PHYP2_23 = 32'h0010_0000;
  localparam logic [31:0] RST_DEEMPH_1 = 32'h0000_0040;
  localparam logic [31:0] RST_ZERO     = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic        valid;
    logic [7:0]  addr;
    logic [15:0] data;
  } pcm_word_t;

  typedef logic [NREG-1:0][31:0] pcm_bank_t;
  typedef pcm_bank_t [NPORT-1:0] pcm_cfg_t;

  typedef struct packed {
    logic       hit;
    logic [2:0] idx;
  } pcm_dec_t;

  ////////////////////////////////////////////////////////////////////////////
  function automatic pcm_bank_t pcm_reset_bank(input int port);
    pcm_bank_t b;
    b = '0;
    b[IDX_LTSSM]  = RST_LTSSM;
    b[IDX_PHYP2]  = (port < 2) ? RST_PHYP2_01 : RST_PHYP2_23;
    b[IDX_DEEMPH] = (port == 1) ? RST_DEEMPH_1 : RST_ZERO;
    return b;
  endfunction : pcm_reset_bank

  localparam pcm_cfg_t RST_CFG = {pcm_reset_bank(3), pcm_reset_bank(2),
                                  pcm_reset_bank(1), pcm_reset_bank(0)};

  // offset to bank slot, shared by the read and write paths
  function automatic pcm_dec_t pcm_decode(input logic [9:0] ofs);
    pcm_dec_t d;
    d.hit = 1'b1;
    d.idx = IDX_LINK;
    case ({ofs[9:2], 2'h0})
      OFS_LINK:   d.idx = IDX_LINK;
      OFS_PHYP2:  d.idx = IDX_PHYP2;
      OFS_PHYCTL: d.idx = IDX_PHYCTL;
      OFS_DCNT:   d.idx = IDX_DCNT;
      OFS_PHYP3:  d.idx = IDX_PHYP3;
      OFS_PML1:   d.idx = IDX_PML1;
      OFS_DEEMPH: d.idx = IDX_DEEMPH;
      OFS_LTSSM:  d.idx = IDX_LTSSM;
      default:    d.hit = 1'b0;
    endcase
    return d;
  endfunction : pcm_decode

  function automatic logic [31:0] pcm_strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    for (int i = 0; i < 4; i++)
    begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction : pcm_strb_mask

endpackage : pcm_pkg

// [rtl/pcm_word_map.sv]
// scatter of one configuration memory word into per-register masks/values
// assumes the word arrives already read and checked by the memory reader
`timescale 1ns/1ns
module pcm_word_map
  import pcm_pkg::*;
(
  // incoming word
  input  pcm_pkg::pcm_word_t word,
  // scatter result
  output logic               hit,
  output logic [1:0]         port,
  output pcm_pkg::pcm_bank_t mask,
  output pcm_pkg::pcm_bank_t value
);

  always_comb
  begin
    hit   = 1'b0;
    port  = word.addr[2:1];
    mask  = '0;
    value = '0;
    // odd addresses are not word starts and are dropped
    if (word.valid && !word.addr[0])
    begin
      case (word.addr[7:3])
        WADR_LINK0[7:3]:
        begin
          hit = 1'b1;
          mask[IDX_LINK] = MSK_SPEED_EN;
          value[IDX_LINK][POS_SPEED_EN] = word.data[15];
        end
        WADR_LTSSM0[7:3]:
        begin
          hit = 1'b1;
          mask[IDX_LTSSM] = MSK_LTSSM;
          value[IDX_LTSSM][POS_LTSSM +: 8] = word.data[7:0];
          mask[IDX_PML1] = MSK_PML1;
          value[IDX_PML1][POS_L1_ALL] = word.data[12];
          value[IDX_PML1][POS_L1_OFF] = word.data[13];
          value[IDX_PML1][POS_CLKREQ +: 2] = word.data[15:14];
        end
        WADR_PHYP2_0[7:3]:
        begin
          hit = 1'b1;
          mask[IDX_PHYP2] = MSK_P2HI;
          value[IDX_PHYP2][POS_P2HI +: 15] = word.data[14:0];
        end
        WADR_PHYCTL0[7:3]:
        begin
          hit = 1'b1;
          mask[IDX_PHYCTL] = MSK_PHYCTL;
          value[IDX_PHYCTL][POS_PHYCTL +: 16] = word.data;
        end
        WADR_MIXED0[7:3]:
        begin
          // only ports 0 and 1 have a mixed word in this range
          if (!word.addr[2])
          begin
            hit = 1'b1;
            mask[IDX_PHYP2] = MSK_P2LO;
            value[IDX_PHYP2][POS_P2LO +: 5] = word.data[4:0];
            mask[IDX_PHYP3] = MSK_P3;
            value[IDX_PHYP3][POS_P3 +: 7] = word.data[11:5];
            mask[IDX_DEEMPH] = MSK_DEEMPH;
            value[IDX_DEEMPH][POS_DEEMPH] = word.data[12];
            mask[IDX_LINK] = MSK_CMPL_DET;
            value[IDX_LINK][POS_CMPL_DET] = word.data[13];
            mask[IDX_DCNT] = MSK_DCNT;
            value[IDX_DCNT][POS_DCNT +: 2] = word.data[15:14];
          end
        end
        default: ;
      endcase
    end
  end

endmodule : pcm_word_map

// [rtl/pcm_loader.sv]
// per-port phy configuration registers, loaded from memory words and axi
// assumes memory words arrive as single-cycle strobes on aclk
`timescale 1ns/1ns

// Contract
// - ltssm word low byte to 33ch bits 7:0
// - link word bit 12 to 98h bit 24
// - link word bit 13 to 98h bit 25
// - link word bits 15:14 to 98h 27:26
// - words 30h-36h bits 14:0 to 7ch 30:16
// - words 38h-3eh all bits to 80h 15:0
// - mixed word bits 4:0 to 7ch 12:8
// - mixed word bits 11:5 to 90h 6:0
// - mixed word bit 12 to f0h bit 6
// - mixed word bit 13 to 78h bit 11
// - mixed word bits 15:14 to 8ch 9:8
// - mixed defaults 001dh port0, 101dh port1
// - prior link word bit 15 to 78h 14
module pcm_loader
  import pcm_pkg::*;
(
  // clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // axi4-lite write address and data
  input  wire logic [pcm_pkg::AXI_AW-1:0] s_awaddr,
  input  wire logic                    s_awvalid,
  output logic                         s_awready,
  input  wire logic [31:0]             s_wdata,
  input  wire logic [3:0]              s_wstrb,
  input  wire logic                    s_wvalid,
  output logic                         s_wready,
  // axi4-lite write response
  output logic [1:0]                   s_bresp,
  output logic                         s_bvalid,
  input  wire logic                    s_bready,
  // axi4-lite read
  input  wire logic [pcm_pkg::AXI_AW-1:0] s_araddr,
  input  wire logic                    s_arvalid,
  output logic                         s_arready,
  output logic [31:0]                  s_rdata,
  output logic [1:0]                   s_rresp,
  output logic                         s_rvalid,
  input  wire logic                    s_rready,
  // memory word strobe
  input  wire pcm_pkg::pcm_word_t      rom_word,
  // configuration out to the ports
  output pcm_pkg::pcm_cfg_t            port_cfg
);
  import pcm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  pcm_cfg_t            cfg_reg;
  pcm_cfg_t            cfg_next;
  logic                awready_reg;
  logic                wready_reg;
  logic                bvalid_reg;
  logic [1:0]          bresp_reg;
  logic                arready_reg;
  logic                rvalid_reg;
  logic [1:0]          rresp_reg;
  logic [31:0]         rdata_reg;
  logic                aw_held_reg;
  logic                w_held_reg;
  logic [AXI_AW-1:0]   waddr_reg;
  logic [31:0]         wdata_reg;
  logic [3:0]          wstrb_reg;
  logic [15:0]         word_cnt_reg;
  logic [7:0]          last_addr_reg;

  logic                aw_hs;
  logic                w_hs;
  logic                ar_hs;
  logic                wr_fire;
  logic                aw_held_next;
  logic                w_held_next;
  logic                bvalid_next;
  logic                rvalid_next;
  pcm_dec_t            wr_dec;
  pcm_dec_t            rd_dec;
  logic [1:0]          wr_port;
  logic [1:0]          rd_port;
  logic [31:0]         smask;
  logic                map_hit;
  logic [1:0]          map_port;
  pcm_bank_t           map_mask;
  pcm_bank_t           map_value;

  ////////////////////////////////////////////////////////////////////////////
  // word scatter
  pcm_word_map u_map (
    .word  (rom_word),
    .hit   (map_hit),
    .port  (map_port),
    .mask  (map_mask),
    .value (map_value)
  );

  ////////////////////////////////////////////////////////////////////////////
  // write channel handshakes
  assign aw_hs   = s_awvalid && awready_reg;
  assign w_hs    = s_wvalid && wready_reg;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_dec  = pcm_decode(waddr_reg[9:0]);
  assign wr_port = waddr_reg[11:10];
  assign smask   = pcm_strb_mask(wstrb_reg);

  always_comb
  begin
    aw_held_next = (aw_held_reg || aw_hs) && !wr_fire;
    w_held_next  = (w_held_reg || w_hs) && !wr_fire;
    bvalid_next  = wr_fire || (bvalid_reg && !s_bready);
  end

  // address and data are taken in either order; response after both
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      waddr_reg   <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
    end
    else
    begin
      aw_held_reg <= aw_held_next;
      w_held_reg  <= w_held_next;
      awready_reg <= !aw_held_next && !bvalid_next;
      wready_reg  <= !w_held_next && !bvalid_next;
      bvalid_reg  <= bvalid_next;
      if (aw_hs)
        waddr_reg <= s_awaddr;
      if (w_hs)
      begin
        wdata_reg <= s_wdata;
        wstrb_reg <= s_wstrb;
      end
      // status word is read-only but writing it is harmless
      if (wr_fire)
        bresp_reg <= (wr_dec.hit || waddr_reg[9:2] == OFS_STATUS[9:2])
                     ? RESP_OKAY : RESP_SLVERR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register banks: loader bits win over a software write in the same cycle
  always_comb
  begin
    cfg_next = cfg_reg;
    for (int p = 0; p < NPORT; p++)
    begin
      for (int r = 0; r < NREG; r++)
      begin
        if (wr_fire && wr_dec.hit && wr_port == 2'(p) && wr_dec.idx == 3'(r))
          cfg_next[p][r] = (cfg_next[p][r] & ~smask) | (wdata_reg & smask);
        if (map_hit && map_port == 2'(p))
          cfg_next[p][r] = (cfg_next[p][r] & ~map_mask[r])
                         | (map_value[r] & map_mask[r]);
      end
    end
  end

  // reset image holds the default words, so unloaded bits keep it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cfg_reg <= RST_CFG;
    else
      cfg_reg <= cfg_next;
  end

  assign port_cfg = cfg_reg;

  ////////////////////////////////////////////////////////////////////////////
  // load status: words taken and the last one seen
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      word_cnt_reg  <= '0;
      last_addr_reg <= '0;
    end
    else if (map_hit)
    begin
      word_cnt_reg  <= word_cnt_reg + 16'h0001;
      last_addr_reg <= rom_word.addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel: one read in flight, answer on the next cycle
  assign ar_hs   = s_arvalid && arready_reg;
  assign rd_dec  = pcm_decode(s_araddr[9:0]);
  assign rd_port = s_araddr[11:10];
  assign rvalid_next = ar_hs || (rvalid_reg && !s_rready);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= RESP_OKAY;
      rdata_reg   <= '0;
    end
    else
    begin
      arready_reg <= !rvalid_next;
      rvalid_reg  <= rvalid_next;
      if (ar_hs)
      begin
        if (rd_dec.hit)
        begin
          rdata_reg <= cfg_reg[rd_port][rd_dec.idx];
          rresp_reg <= RESP_OKAY;
        end
        else if (s_araddr[9:2] == OFS_STATUS[9:2])
        begin
          rdata_reg <= {8'h00, last_addr_reg, word_cnt_reg};
          rresp_reg <= RESP_OKAY;
        end
        else
        begin
          rdata_reg <= '0;
          rresp_reg <= RESP_SLVERR;
        end
      end
    end
  end

  assign s_awready = awready_reg;
  assign s_wready  = wready_reg;
  assign s_bvalid  = bvalid_reg;
  assign s_bresp   = bresp_reg;
  assign s_arready = arready_reg;
  assign s_rvalid  = rvalid_reg;
  assign s_rdata   = rdata_reg;
  assign s_rresp   = rresp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_ltssm_copy:
  assert property (@(posedge aclk) disable iff (!aresetn)
    rom_word.valid && rom_word.addr == 8'h2a |=>
      cfg_reg[1][IDX_LTSSM][7:0] == $past(rom_word.data[7:0]))
  else $error("ltssm byte not copied to port 1");

  a_l1_all_bit:
  assert property (@(posedge aclk) disable iff (!aresetn)
    rom_word.valid && rom_word.addr == 8'h2c |=>
      cfg_reg[2][IDX_PML1][24] == $past(rom_word.data[12]))
  else $error("l1 apply-all bit wrong on port 2");

  a_l1_off_bit:
  assert property (@(posedge aclk) disable iff (!aresetn)
    rom_word.valid && rom_word.addr == 8'h2e ##1 1'b1 |->
      cfg_reg[3][IDX_PML1][25] == $past(rom_word.data[13]))
  else $error("l1 entry-off bit wrong on port 3");

  a_clkreq_field:
  assert property (@(posedge aclk) disable iff (!aresetn)
    rom_word.valid && rom_word.addr == 8'h28 |=>
      cfg_reg[0][IDX_PML1][27:26] == $past(rom_word.data[15:14]))
  else $error("clock request field wrong on port 0");

  a_phyp2_high:
  assert property (@(posedge aclk) disable iff (!aresetn)
    rom_word.valid && rom_word.addr == 8'h32 |=>
      cfg_reg[1][IDX_PHYP2][30:16] == $past(rom_word.data[14:0]))
  else $error("phy parameter 2 high field wrong on port 1");

  a_phyctl_load:
  assert property (@(posedge aclk) disable iff (!aresetn)
    rom_word.valid && rom_word.addr == 8'h3e |=>
      cfg_reg[3][IDX_PHYCTL][15:0] == $past(rom_word.data))
  else $error("phy control word wrong on port 3");

  a_mixed_scatter:
  assert property (@(posedge aclk) disable iff (!aresetn)
    rom_word.valid && rom_word.addr == 8'h40 |=>
      cfg_reg[0][IDX_PHYP2][12:8] == $past(rom_word.data[4:0]) &&
      cfg_reg[0][IDX_PHYP3][6:0] == $past(rom_word.data[11:5]) &&
      cfg_reg[0][IDX_DEEMPH][6] == $past(rom_word.data[12]) &&
      cfg_reg[0][IDX_LINK][11] == $past(rom_word.data[13]) &&
      cfg_reg[0][IDX_DCNT][9:8] == $past(rom_word.data[15:14]))
  else $error("mixed word scatter wrong on port 0");

  a_mixed_default:
  assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) == 1'b0 |->
      cfg_reg[1][IDX_DEEMPH][6] && !cfg_reg[0][IDX_DEEMPH][6] &&
      cfg_reg[0][IDX_PHYP2][12:8] == 5'h1d &&
      cfg_reg[1][IDX_PHYP2][12:8] == 5'h1d)
  else $error("mixed word defaults not applied");

  a_speed_enable:
  assert property (@(posedge aclk) disable iff (!aresetn)
    rom_word.valid && rom_word.addr == 8'h24 |=>
      cfg_reg[2][IDX_LINK][14] == $past(rom_word.data[15]))
  else $error("speed change enable wrong on port 2");

  a_port_isolate:
  assert property (@(posedge aclk) disable iff (!aresetn)
    rom_word.valid && rom_word.addr == 8'h28 && !wr_fire |=>
      $stable(cfg_reg[1]) && $stable(cfg_reg[2]) && $stable(cfg_reg[3]))
  else $error("load touched another port");

endmodule : pcm_loader

// [tb/pcm_rom_model.sv]
// model of the serial configuration memory feeding the word strobe
// assumes the bench pokes words and requests fetches on aclk
`timescale 1ns/1ns
module pcm_rom_model
  import pcm_pkg::*;
(
  // clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // bench side
  input  wire logic          poke,
  input  wire logic          fetch,
  input  wire logic [7:0]    f_addr,
  input  wire logic [15:0]   p_data,
  // word strobe to the loader
  output pcm_pkg::pcm_word_t rom_word
);
  logic [15:0] mem [0:255];
  //////////////////////////////////////////////////////////////////////////
  // contents start as the default words
  initial
  begin
    for (int i = 0; i < 256; i++)
    begin
      mem[i] = 16'h0000;
    end
    for (int p = 0; p < 4; p++)
    begin
      mem[8'h28 + 2 * p] = 16'h0004;
      mem[8'h30 + 2 * p] = 16'h0010;
    end
    mem[8'h40] = 16'h001d;
    mem[8'h42] = 16'h101d;
  end
  // idle lines flip every cycle so stale data is never mistaken for a word
  always @(posedge aclk)
  begin
    if (poke)
      mem[f_addr] <= p_data;
    if (!aresetn)
      rom_word <= '0;
    else if (fetch)
      rom_word <= {1'b1, f_addr, mem[f_addr]};
    else
      rom_word <= {1'b0, ~rom_word.addr, ~rom_word.data};
  end
endmodule : pcm_rom_model

// [tb/testbench.sv]
// self-checking bench for the per-port configuration map
// assumes pcm_pkg, pcm_loader and the memory model are compiled first
`timescale 1ns/1ns
`define CMP(a, b) \
  begin \
    n_compared++; \
    if ((a) !== (b)) \
    begin \
      fails++; \
      $display("[ERR] %0t got %h want %h", $time, (a), (b)); \
    end \
  end
module testbench;
  import pcm_pkg::*;
  logic              aclk, aresetn, poke, fetch;
  logic              s_awvalid, s_awready, s_wvalid, s_wready;
  logic              s_bvalid, s_bready, s_arvalid, s_arready;
  logic              s_rvalid, s_rready;
  logic [AXI_AW-1:0] s_awaddr, s_araddr;
  logic [31:0]       s_wdata, s_rdata;
  logic [3:0]        s_wstrb;
  logic [1:0]        s_bresp, s_rresp;
  logic [7:0]        f_addr, last_a;
  logic [15:0]       p_data;
  pcm_word_t         rom_word;
  pcm_cfg_t          port_cfg, exp_cfg;
  int                fails, n_compared, n_words, cycles;

  pcm_loader pcm_loader_i (
    .aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
    .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
    .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
    .s_rready, .rom_word, .port_cfg);
  pcm_rom_model pcm_rom_model_i (
    .aclk, .aresetn, .poke, .fetch, .f_addr, .p_data, .rom_word);

  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // whole run needs a few hundred cycles
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      $display("[ERR] %0t timeout", $time);
      close_out();
    end
  end

  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out

  //////////////////////////////////////////////////////////////////////////
  // reference and checks
  task automatic chk_all();
    @(negedge aclk);
    for (int p = 0; p < NPORT; p++)
    begin
      for (int i = 0; i < NREG; i++)
      begin
        `CMP(port_cfg[p][i], exp_cfg[p][i])
      end
    end
  endtask : chk_all

  task automatic upd(input logic [7:0] a, input logic [15:0] d,
                     input logic cnt_only);
    logic [1:0] p;
    p = a[2:1];
    if (a[0] || a < 8'h20 || a > 8'h42)
      return;
    n_words++;
    last_a = a;
    if (cnt_only)
      return;
    case (a[7:3])
      5'h04: exp_cfg[p][IDX_LINK][14] = d[15];
      5'h05:
      begin
        exp_cfg[p][IDX_LTSSM][7:0] = d[7:0];
        exp_cfg[p][IDX_PML1][27:24] = d[15:12];
      end
      5'h06: exp_cfg[p][IDX_PHYP2][30:16] = d[14:0];
      5'h07: exp_cfg[p][IDX_PHYCTL][15:0] = d;
      default:
      begin
        exp_cfg[p][IDX_PHYP2][12:8] = d[4:0];
        exp_cfg[p][IDX_PHYP3][6:0] = d[11:5];
        exp_cfg[p][IDX_DEEMPH][6] = d[12];
        exp_cfg[p][IDX_LINK][11] = d[13];
        exp_cfg[p][IDX_DCNT][9:8] = d[15:14];
      end
    endcase
  endtask : upd

  //////////////////////////////////////////////////////////////////////////
  // four words from base, fetched back to back
  task automatic burst(input logic [7:0] base, input logic [15:0] d,
                       input logic dflt);
    for (int p = 0; p < 4; p++)
    begin
      @(posedge aclk);
      poke   <= !dflt;
      f_addr <= base + 8'(2 * p);
      p_data <= d ^ {8{2'(p)}};
    end
    for (int p = 0; p < 5; p++)
    begin
      @(posedge aclk);
      poke   <= 1'b0;
      fetch  <= (p < 4);
      f_addr <= base + 8'(2 * p);
    end
    for (int p = 0; p < 4; p++)
    begin
      upd(base + 8'(2 * p), d ^ {8{2'(p)}}, dflt);
    end
    repeat (2) @(posedge aclk);
  endtask : burst

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata  <= d;
    {s_awvalid, s_wvalid, s_bready} <= 3'b111;
    do @(negedge aclk); while ((s_awready & s_wready) !== 1'b1);
    @(posedge aclk);
    {s_awvalid, s_wvalid} <= 2'b00;
    do @(negedge aclk); while (s_bvalid !== 1'b1);
    `CMP(s_bresp, r)
    @(posedge aclk);
    s_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    @(posedge aclk);
    s_araddr <= a;
    {s_arvalid, s_rready} <= 2'b11;
    do @(negedge aclk); while (s_arready !== 1'b1);
    @(posedge aclk);
    s_arvalid <= 1'b0;
    do @(negedge aclk); while (s_rvalid !== 1'b1);
    `CMP(s_rdata, d)
    `CMP(s_rresp, r)
    @(posedge aclk);
    s_rready <= 1'b0;
  endtask : axi_rd

  //////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_defaults();
    chk_all();
    burst(8'h28, 16'h0, 1'b1);
    burst(8'h30, 16'h0, 1'b1);
    burst(8'h38, 16'h0, 1'b1);
    burst(8'h40, 16'h0, 1'b1);
    chk_all();
  endtask : t_defaults

  task automatic t_fields();
    burst(8'h28, 16'h9a5c, 1'b0);
    chk_all();
    burst(8'h28, 16'h6ca3, 1'b0);
    chk_all();
    burst(8'h30, 16'hffff, 1'b0);
    chk_all();
    burst(8'h38, 16'hc3a5, 1'b0);
    chk_all();
    burst(8'h40, 16'hb6e9, 1'b0);
    chk_all();
    burst(8'h20, 16'h8000, 1'b0);
    chk_all();
  endtask : t_fields

  // odd and out-of-range words leave every port alone
  task automatic t_ignored();
    burst(8'h21, 16'hffff, 1'b0);
    burst(8'h48, 16'hffff, 1'b0);
    burst(8'h18, 16'hffff, 1'b0);
    chk_all();
  endtask : t_ignored

  task automatic t_axi();
    axi_rd(12'hb3c, exp_cfg[2][IDX_LTSSM], RESP_OKAY);
    axi_rd(12'h498, exp_cfg[1][IDX_PML1], RESP_OKAY);
    axi_wr(12'hc80, 32'h1234_5678, RESP_OKAY);
    exp_cfg[3][IDX_PHYCTL] = 32'h1234_5678;
    // partial strobes: only the middle two bytes may change
    @(posedge aclk);
    s_wstrb <= 4'h6;
    axi_wr(12'h08c, 32'ha5a5_a5a5, RESP_OKAY);
    s_wstrb <= 4'hf;
    exp_cfg[0][IDX_DCNT][23:8] = 16'ha5a5;
    burst(8'h38, 16'h0f0f, 1'b0);
    chk_all();
    axi_wr(12'h004, 32'hffff_ffff, RESP_SLVERR);
    axi_rd(12'h004, 32'h0, RESP_SLVERR);
    axi_wr(12'h3fc, 32'hffff_ffff, RESP_OKAY);
    axi_rd(12'h3fc, {8'h00, last_a, n_words[15:0]}, RESP_OKAY);
    chk_all();
  endtask : t_axi

  initial
  begin
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {poke, fetch, s_awaddr, s_araddr, s_wdata, f_addr, p_data} = '0;
    s_wstrb = 4'hf;
    aresetn = 1'b0;
    fails = 0;
    n_compared = 0;
    exp_cfg = '0;
    for (int p = 0; p < NPORT; p++)
    begin
      upd(8'h28 + 8'(2 * p), 16'h0004, 1'b0);
      upd(8'h30 + 8'(2 * p), 16'h0010, 1'b0);
    end
    upd(8'h40, 16'h001d, 1'b0);
    upd(8'h42, 16'h101d, 1'b0);
    n_words = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_defaults();
    t_fields();
    t_ignored();
    t_axi();
    close_out();
  end
endmodule : testbench
